// *** hdl/bit_scan_unit.sv ***
// bit scan datapath with working registers, data store and apb slave
`timescale 1ns/1ps
`include "bit_scan_defs.svh"

module bit_scan_unit
  import bit_scan_pkg::*;
#(
  parameter int DMEM_WORDS = 64
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             carry_flag
);

  localparam int AW = $clog2(DMEM_WORDS);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (DMEM_WORDS < 2 || DMEM_WORDS > `DMEM_MAX_WORDS || (1 << AW) != DMEM_WORDS) begin : g_chk
    $error("DMEM_WORDS must be a power of two from 2 to 256");
  end

  // ----------------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------------
  function automatic scan_op_t decode_op(input logic [12:0] opc);
    scan_op_t op;
    op = OP_NONE;
    case (opc)
      `OPC_FROM_TOP:    op = OP_FROM_TOP;     // RULE_07
      `OPC_FROM_BOTTOM: op = OP_FROM_BOTTOM;  // RULE_08
      `OPC_SIGN_CHANGE: op = OP_SIGN_CHANGE;  // RULE_16
      default:          op = OP_NONE;
    endcase
    return op;
  endfunction

  function automatic logic is_wreg(input logic [11:0] a);
    return (a >= `ADDR_WREG_BASE) && (a <= `ADDR_WREG_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic is_dmem(input logic [11:0] a);
    logic [11:0] top;
    top = 12'(`ADDR_DMEM_BASE + DMEM_WORDS * 4);
    return (a >= `ADDR_DMEM_BASE) && (a < top) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic is_fixed(input logic [11:0] a);
    return (a == `ADDR_INSTR) || (a == `ADDR_STATUS) || (a == `ADDR_RESULT) ||
           (a == `ADDR_LAST_SRC);
  endfunction

  // ----------------------------------------------------------------------
  // scan functions
  // ----------------------------------------------------------------------
  // counter form kept on purpose: it mirrors the documented loop exactly
  function automatic logic [4:0] scan_from_top(input word_t w);
    word_t      t;
    logic [4:0] sh;
    logic       done;
    t    = w;
    sh   = `ONE_SCAN_START;
    done = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (!done && ((t & `TOP_MASK) == `WORD_ZERO)) begin  // RULE_01
        t  = t << 1;                                       // RULE_12
        sh = sh + 5'd1;                                    // RULE_02
      end else begin
        done = 1'b1;
      end
    end
    return (sh == `ONE_SCAN_LIMIT) ? 5'd0 : sh;  // RULE_12
  endfunction

  function automatic logic [4:0] scan_from_bottom(input word_t w);
    word_t      t;
    logic [4:0] sh;
    logic       done;
    t    = w;
    sh   = `ONE_SCAN_START;
    done = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (!done && ((t & `BOTTOM_MASK) == `WORD_ZERO)) begin  // RULE_03
        t  = t >> 1;                                          // RULE_12
        sh = sh + 5'd1;
      end else begin
        done = 1'b1;
      end
    end
    return (sh == `ONE_SCAN_LIMIT) ? 5'd0 : sh;  // RULE_12
  endfunction

  // returns the shift count, 15 meaning no change found
  function automatic logic [4:0] scan_change(input word_t w);
    word_t      t;
    logic [4:0] sh;
    logic       sign;
    logic       done;
    sign = w[15];
    t    = w << 1;
    sh   = 5'd0;
    done = 1'b0;
    for (int i = 0; i < 15; i++) begin
      if (!done && (t[15] == sign)) begin  // RULE_13
        t  = t << 1;
        sh = sh + 5'd1;
      end else begin
        done = 1'b1;
      end
    end
    return sh;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  word_t       wreg_q [16];
  word_t       dmem_q [DMEM_WORDS];
  word_t       result_q;
  word_t       last_src_q;
  logic        carry_q;
  logic        illegal_q;
  logic [31:0] rdata_q;
  logic        err_q;

  // ----------------------------------------------------------------------
  // apb phases and instruction decode
  // ----------------------------------------------------------------------
  logic        setup;
  logic        wr_access;
  logic        instr_wr;
  scan_op_t    op;
  logic [3:0]  dst;
  logic [3:0]  src;
  logic [2:0]  mode;
  logic        mode_ok;
  logic        exec;
  logic        illegal_set;

  assign setup     = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign instr_wr  = wr_access && (paddr == `ADDR_INSTR);
  assign op        = decode_op(pwdata[`INSTR_OPC_MSB:`INSTR_OPC_LSB]);
  assign dst       = pwdata[`INSTR_DST_MSB:`INSTR_DST_LSB];
  assign mode      = pwdata[`INSTR_MODE_MSB:`INSTR_MODE_LSB];
  assign src       = pwdata[`INSTR_SRC_MSB:`INSTR_SRC_LSB];
  assign mode_ok   = (mode <= `MODE_PRE_INC);
  // whole scan runs in the access cycle of the one instruction write
  assign exec        = instr_wr && (op != OP_NONE) && mode_ok;  // RULE_11
  assign illegal_set = instr_wr && !((op != OP_NONE) && mode_ok);

  // ----------------------------------------------------------------------
  // operand fetch
  // ----------------------------------------------------------------------
  word_t       src_reg;
  word_t       ptr_eff;
  word_t       ptr_new;
  logic        ptr_wr;
  logic [AW-1:0] mem_idx;
  word_t       operand;

  assign src_reg = wreg_q[src];  // RULE_10

  always_comb begin
    ptr_eff = src_reg;
    ptr_new = src_reg;
    ptr_wr  = 1'b0;
    case (mode)  // RULE_09
      `MODE_POST_DEC: begin
        ptr_new = src_reg - `PTR_STEP;  // RULE_17
        ptr_wr  = 1'b1;
      end
      `MODE_POST_INC: begin
        ptr_new = src_reg + `PTR_STEP;  // RULE_17
        ptr_wr  = 1'b1;
      end
      `MODE_PRE_DEC: begin
        ptr_eff = src_reg - `PTR_STEP;
        ptr_new = ptr_eff;
        ptr_wr  = 1'b1;
      end
      `MODE_PRE_INC: begin
        ptr_eff = src_reg + `PTR_STEP;
        ptr_new = ptr_eff;
        ptr_wr  = 1'b1;
      end
      default: begin
        ptr_eff = src_reg;
        ptr_new = src_reg;
        ptr_wr  = 1'b0;
      end
    endcase
  end

  // pointers are byte addresses; bit 0 is ignored and the store wraps
  assign mem_idx = ptr_eff[AW:1];
  assign operand = (mode == `MODE_DIRECT) ? src_reg : dmem_q[mem_idx];  // RULE_09

  // ----------------------------------------------------------------------
  // scan result
  // ----------------------------------------------------------------------
  logic [4:0] top_pos;
  logic [4:0] bot_pos;
  logic [4:0] chg_sh;
  logic [4:0] chg_num;
  word_t      result;
  logic       carry_new;

  assign top_pos = scan_from_top(operand);
  assign bot_pos = scan_from_bottom(operand);
  assign chg_sh  = scan_change(operand);
  assign chg_num = 5'd0 - chg_sh;  // RULE_14

  always_comb begin
    result    = `WORD_ZERO;
    carry_new = 1'b0;
    case (op)
      OP_FROM_TOP: begin
        result    = {11'h000, top_pos};    // RULE_06
        carry_new = (top_pos == 5'd0);     // RULE_04 RULE_05
      end
      OP_FROM_BOTTOM: begin
        result    = {11'h000, bot_pos};    // RULE_06
        carry_new = (bot_pos == 5'd0);     // RULE_04 RULE_05
      end
      OP_SIGN_CHANGE: begin
        result    = {{11{chg_num[4]}}, chg_num};          // RULE_14
        carry_new = (chg_sh == `CHANGE_MAX_SHIFT);        // RULE_15
      end
      default: begin
        result    = `WORD_ZERO;
        carry_new = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // working registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        wreg_q[i] <= `WORD_RESET;
      end
    end else if (wr_access && is_wreg(paddr)) begin
      wreg_q[paddr[5:2]] <= pwdata[15:0];
    end else if (exec) begin
      if (ptr_wr) begin
        wreg_q[src] <= ptr_new;  // RULE_17
      end
      // destination written last so it wins over a pointer update
      wreg_q[dst] <= result;  // RULE_04 RULE_05 RULE_10
    end
  end

  // ----------------------------------------------------------------------
  // data store
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < DMEM_WORDS; i++) begin
        dmem_q[i] <= `WORD_RESET;
      end
    end else if (wr_access && is_dmem(paddr)) begin
      dmem_q[paddr[AW+1:2]] <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // status, result and last operand
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      carry_q <= `CARRY_RESET;
    end else if (exec) begin
      carry_q <= carry_new;  // RULE_17
    end else if (wr_access && (paddr == `ADDR_STATUS)) begin
      carry_q <= pwdata[`STAT_CARRY_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      illegal_q <= `ILLEGAL_RESET;
    end else if (illegal_set) begin
      illegal_q <= 1'b1;
    end else if (wr_access && (paddr == `ADDR_STATUS) && pwdata[`STAT_ILLEGAL_BIT]) begin
      illegal_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_q   <= `WORD_RESET;
      last_src_q <= `WORD_RESET;
    end else if (exec) begin
      result_q   <= result;
      last_src_q <= operand;
    end
  end

  // ----------------------------------------------------------------------
  // apb read path
  // ----------------------------------------------------------------------
  // read data is caught at the setup edge so prdata comes from flops
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else if (setup) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= !(is_fixed(paddr) || is_wreg(paddr) || is_dmem(paddr));
      if (!pwrite) begin
        if (paddr == `ADDR_STATUS) begin
          rdata_q <= {30'h0, illegal_q, carry_q};
        end else if (paddr == `ADDR_RESULT) begin
          rdata_q <= {16'h0000, result_q};
        end else if (paddr == `ADDR_LAST_SRC) begin
          rdata_q <= {16'h0000, last_src_q};
        end else if (is_wreg(paddr)) begin
          rdata_q <= {16'h0000, wreg_q[paddr[5:2]]};
        end else if (is_dmem(paddr)) begin
          rdata_q <= {16'h0000, dmem_q[paddr[AW+1:2]]};
        end
      end else if (paddr == `ADDR_INSTR) begin
        err_q <= !((decode_op(pwdata[`INSTR_OPC_MSB:`INSTR_OPC_LSB]) != OP_NONE) &&
                   (pwdata[`INSTR_MODE_MSB:`INSTR_MODE_LSB] <= `MODE_PRE_INC));
      end
    end
  end

  assign prdata     = rdata_q;
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & err_q;
  assign carry_flag = carry_q;

endmodule

// *** hdl/bit_scan_defs.svh ***
// offsets, fields, encodings and reset values of the bit scan unit
// What this block does
// [RULE_01] The top scan looks at the source word from bit 15 toward bit 0 and stops at the first one.
// [RULE_02] The top scan numbers bit 15 as position 1 and bit 0 as position 16.
// [RULE_03] The bottom scan looks from bit 0 upward and numbers bit 0 as 1 and bit 15 as 16.
// [RULE_04] A one scan over a word with no set bit writes zero and sets carry.
// [RULE_05] A one scan that finds a set bit clears carry and writes the found position.
// [RULE_06] A one scan position is zero padded to a full 16-bit word before it is stored.
// [RULE_07] The top scan is the opcode 1100 1111 1000 0 then destination, mode and source fields.
// [RULE_08] The bottom scan is the opcode 1100 1111 0000 0 with the same field layout.
// [RULE_09] The 3-bit mode picks direct, indirect, post-inc/dec or pre-inc/dec source fetch.
// [RULE_10] Any of the 16 working registers may be source or destination, word width only.
// [RULE_11] Each scan is one instruction word and completes in one cycle.
// [RULE_12] One scans act as a counter from 1 to a limit of 17 testing mask 8000 or 0001.
// [RULE_13] The change scan searches down from bit 14 for the first bit unlike the sign bit.
// [RULE_14] The change scan numbers bit 14 as 0 down to -14 for bit 0, sign extended to 16 bits.
// [RULE_15] With no differing bit the change scan returns -15 and sets carry, else clears carry.
// [RULE_16] The change scan is the opcode 1101 1111 0000 0 with the same field layout.
// [RULE_17] Scans change only carry among status bits, and pointer updates step by two.
`ifndef BIT_SCAN_DEFS_SVH
`define BIT_SCAN_DEFS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define ADDR_INSTR      12'h000
`define ADDR_STATUS     12'h004
`define ADDR_RESULT     12'h008
`define ADDR_LAST_SRC   12'h00c
`define ADDR_WREG_BASE  12'h040
`define ADDR_WREG_LAST  12'h07c
`define ADDR_DMEM_BASE  12'h400
`define DMEM_MAX_WORDS  256

// ----------------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------------
`define OPC_FROM_TOP     13'h19f0
`define OPC_FROM_BOTTOM  13'h19e0
`define OPC_SIGN_CHANGE  13'h1be0
`define INSTR_OPC_MSB    23
`define INSTR_OPC_LSB    11
`define INSTR_DST_MSB    10
`define INSTR_DST_LSB    7
`define INSTR_MODE_MSB   6
`define INSTR_MODE_LSB   4
`define INSTR_SRC_MSB    3
`define INSTR_SRC_LSB    0

`define MODE_DIRECT      3'h0
`define MODE_INDIRECT    3'h1
`define MODE_POST_DEC    3'h2
`define MODE_POST_INC    3'h3
`define MODE_PRE_DEC     3'h4
`define MODE_PRE_INC     3'h5

// ----------------------------------------------------------------------
// status bits, reset values, scan constants
// ----------------------------------------------------------------------
`define STAT_CARRY_BIT    0
`define STAT_ILLEGAL_BIT  1
`define CARRY_RESET       1'b0
`define ILLEGAL_RESET     1'b0
`define WORD_RESET        16'h0000
`define WORD_ZERO         16'h0000
`define TOP_MASK          16'h8000
`define BOTTOM_MASK       16'h0001
`define ONE_SCAN_START    5'd1
`define ONE_SCAN_LIMIT    5'd17
`define CHANGE_MAX_SHIFT  5'd15
`define PTR_STEP          16'h0002

`endif

// *** hdl/bit_scan_pkg.sv ***
// types shared by the bit scan unit
package bit_scan_pkg;

  typedef logic [15:0] word_t;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_FROM_TOP,
    OP_FROM_BOTTOM,
    OP_SIGN_CHANGE
  } scan_op_t;

endpackage

// *** verification/bit_scan_properties.sv ***
// port-level checks of the bit scan unit
`timescale 1ns/1ps
`include "bit_scan_defs.svh"
module bit_scan_properties #(
  parameter int DMEM_WORDS = 64
) (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        carry_flag
);
  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  logic acc;
  logic iwr;
  logic legal;
  logic rres;
  assign acc   = psel && penable;
  assign iwr   = acc && pwrite && paddr == `ADDR_INSTR;
  assign rres  = acc && !pwrite && paddr == `ADDR_RESULT;
  assign legal = (pwdata[23:11] == `OPC_FROM_TOP || pwdata[23:11] == `OPC_FROM_BOTTOM ||
                  pwdata[23:11] == `OPC_SIGN_CHANGE) && pwdata[6:4] <= `MODE_PRE_INC;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_access: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
  chk_legal_ok: assert property (iwr && legal |-> !pslverr)
    else $error("legal scan refused");
  chk_illegal_held: assert property (iwr && !legal |-> pslverr ##1 $stable(carry_flag))
    else $error("illegal scan accepted");
  chk_carry_cause: assert property ($changed(carry_flag) |->
    $past(acc && pwrite && (paddr == `ADDR_INSTR || paddr == `ADDR_STATUS)))
    else $error("carry moved without cause");
  chk_status_wr: assert property (acc && pwrite && paddr == `ADDR_STATUS |=>
    carry_flag == $past(pwdata[0])) else $error("status write lost");
  chk_status_mirror: assert property (acc && !pwrite && paddr == `ADDR_STATUS |->
    prdata[0] == carry_flag) else $error("status carry mismatch");
  chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_one_scan: assert property (
    iwr && legal && pwdata[23:11] != `OPC_SIGN_CHANGE ##2 rres
    |-> prdata <= 32'h10 && carry_flag == (prdata == 32'h0))
    else $error("one scan result out of range");
  chk_change_scan: assert property (
    iwr && legal && pwdata[23:11] == `OPC_SIGN_CHANGE ##2 rres
    |-> (prdata[15:0] >= 16'hfff1 || prdata[15:0] == 16'h0) &&
        carry_flag == (prdata[15:0] == 16'hfff1))
    else $error("change scan result out of range");
  chk_reset_carry: assert property (disable iff (1'b0) rst |=> !carry_flag)
    else $error("carry not cleared by reset");
endmodule

bind bit_scan_unit bit_scan_properties #(.DMEM_WORDS(DMEM_WORDS)) u_props (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .carry_flag(carry_flag));

// *** verification/tb.sv ***
// self-checking bench for the bit scan unit
`timescale 1ns/1ps
`include "bit_scan_defs.svh"
module tb
  import bit_scan_pkg::*;
;
  typedef struct {logic rd; logic [31:0] data; logic err;} note_t;
  localparam int DW = 64;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, carry_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  note_t       notes[$];
  note_t       cur;
  word_t       fixed[8];
  int          failures, total_checks, seed;

  bit_scan_unit #(.DMEM_WORDS(DW)) DUT (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .carry_flag(carry_flag));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------------
  // compare, bus and model tasks
  // ----------------------------------------------------------------------
  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic cmp_flag(input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // request held until pready is seen; release is left to the next call or idle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic er);
    int n;
    notes.push_back('{!w, e, er});
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
  endtask

  task automatic idle;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  function automatic logic [11:0] wreg(input logic [3:0] i);
    return `ADDR_WREG_BASE + {6'h00, i, 2'b00};
  endfunction

  function automatic logic [11:0] dmem(input logic [15:0] p);
    return `ADDR_DMEM_BASE + 12'(((p >> 1) % DW) * 4);
  endfunction

  function automatic logic [16:0] exp_scan(input logic [1:0] k, input logic [15:0] w);
    logic [15:0] r;
    r = (k == 2'd2) ? 16'hfff1 : 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (k == 2'd0 && w[i]) r = 16'(16 - i);
      if (k == 2'd1 && w[15-i]) r = 16'(16 - i);
      if (k == 2'd2 && i < 15 && w[i] != w[15]) r = 16'(i - 14);
    end
    return {(k == 2'd2) ? r == 16'hfff1 : r == 16'h0000, r};
  endfunction

  // load operand, run one scan, read back every visible effect
  task automatic scan(input logic [1:0] k, input logic [2:0] m, input logic [3:0] dst,
                      input logic [3:0] src, input logic [15:0] op, input logic [15:0] p);
    logic [12:0] opc;
    logic [15:0] ea, fp;
    logic [16:0] r;
    opc = k == 2'd0 ? `OPC_FROM_TOP : k == 2'd1 ? `OPC_FROM_BOTTOM : `OPC_SIGN_CHANGE;
    ea = m == `MODE_PRE_DEC ? p - `PTR_STEP : m == `MODE_PRE_INC ? p + `PTR_STEP : p;
    fp = (m == `MODE_POST_DEC || m == `MODE_PRE_DEC) ? p - `PTR_STEP :
         (m == `MODE_POST_INC || m == `MODE_PRE_INC) ? p + `PTR_STEP : p;
    r = exp_scan(k, op);
    xfer(1'b1, wreg(src), {16'h0, m == `MODE_DIRECT ? op : p}, 32'h0, 1'b0);
    if (m != `MODE_DIRECT) xfer(1'b1, dmem(ea), {16'h0, op}, 32'h0, 1'b0);
    xfer(1'b1, `ADDR_INSTR, {8'h00, opc, dst, m, src}, 32'h0, 1'b0);
    xfer(1'b0, `ADDR_RESULT, 32'h0, {16'h0, r[15:0]}, 1'b0);
    xfer(1'b0, wreg(dst), 32'h0, {16'h0, r[15:0]}, 1'b0);
    xfer(1'b0, `ADDR_STATUS, 32'h0, {31'h0, r[16]}, 1'b0);
    xfer(1'b0, `ADDR_LAST_SRC, 32'h0, {16'h0, op}, 1'b0);
    if (m != `MODE_DIRECT && dst != src) xfer(1'b0, wreg(src), 32'h0, {16'h0, fp}, 1'b0);
  endtask

  // ----------------------------------------------------------------------
  // output watcher and watchdog
  // ----------------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst && psel && penable && pready === 1'b1 && notes.size() > 0) begin
      cur = notes.pop_front();
      cmp_flag(cur.err, pslverr);
      if (cur.rd) cmp_word(cur.data, prdata);
      if (cur.rd && paddr == `ADDR_STATUS) begin
        cmp_flag(cur.data[0], carry_flag);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    give_verdict;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; seed = 8; failures = 0; total_checks = 0;
    fixed = '{16'h0000, 16'h8000, 16'h0001, 16'hffff, 16'h55ff, 16'hff0a, 16'h000a, 16'h7fff};
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    xfer(1'b0, `ADDR_STATUS, 32'h0, 32'h0, 1'b0);
    xfer(1'b0, wreg(4'h5), 32'h0, 32'h0, 1'b0);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
      for (int k = 0; k < 3; k++)
        scan(2'(k), 3'(i % 6), 4'(i + k), 4'(15 - i), fixed[i], 16'(16 + 4 * i));
    $display("test fixed words done");
    repeat (40) begin
      rv = $random(seed);
      scan(2'(rv[17:16] % 3), 3'(rv[20:18] % 6), rv[24:21], rv[28:25], rv[15:0],
           {9'h0, rv[31:26], 1'b0});
    end
    $display("test random words done");
    xfer(1'b1, `ADDR_STATUS, 32'h1, 32'h0, 1'b0);
    xfer(1'b1, `ADDR_INSTR, 32'h00abcd, 32'h0, 1'b1);
    xfer(1'b1, `ADDR_INSTR, {8'h00, `OPC_FROM_TOP, 4'h1, 3'h6, 4'h2}, 32'h0, 1'b1);
    xfer(1'b0, `ADDR_STATUS, 32'h0, 32'h3, 1'b0);
    xfer(1'b1, `ADDR_STATUS, 32'h2, 32'h0, 1'b0);
    xfer(1'b0, `ADDR_STATUS, 32'h0, 32'h0, 1'b0);
    $display("test illegal done");
    scan(2'd1, `MODE_DIRECT, 4'h2, 4'h3, 16'h0400, 16'h0);
    xfer(1'b1, `ADDR_RESULT, 32'h1234, 32'h0, 1'b0);
    xfer(1'b0, `ADDR_RESULT, 32'h0, 32'hb, 1'b0);
    xfer(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
    xfer(1'b1, 12'h002, 32'hffff, 32'h0, 1'b1);
    xfer(1'b0, `ADDR_DMEM_BASE + 12'(4 * DW), 32'h0, 32'h0, 1'b1);
    idle;
    $display("test map done");
    give_verdict;
  end
endmodule
